/* File: design/irq_flags_map.svh */
// Register offsets, bit positions and reset values of the interrupt flag bank
//
// Behaviour
// - Flag reads 1 once its source requested
// - Low bit 15, high bit 2 read zero
// - Low bits 14, 4: DMA channel 1, 0
// - Low bit 13: first ADC conversion done
// - Low bits 12, 11: first UART tx, rx
// - Low bits 10, 9: first SPI event, fault
// - Low bits 8, 7, 3: timers 3, 2, 1
// - Low bits 6, 5: compare 2, capture 2
// - Low bits 2, 1: compare 1, capture 1
// - Low bit 0: external interrupt input 0
// - High bits 15, 14: second UART tx, rx
// - High bits 13, 4: external inputs 2, 1
// - High bits 12, 11: timers 5, 4
// - High bits 10, 9: compare 4, 3
// - High bit 8: DMA channel 2 done
// - High bits 7, 6: capture 8, 7
// - High bit 5: second ADC conversion done
// - High bit 3: pin change notification
// - High bits 1, 0: first I2C master, slave
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH

// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define ADDR_FLAGS_LOW 4'h0
`define ADDR_FLAGS_HIGH 4'h1

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define FLAGS_RST 16'h0000
`define FLAGS_LOW_IMPL 16'h7fff
`define FLAGS_HIGH_IMPL 16'hfffb
`define RDATA_IDLE 16'h0000

// ----------------------------------------------------------------
// Bit positions in the low flag register
// ----------------------------------------------------------------
`define BIT_LOW_UNUSED 15
`define BIT_DMA_CH1_DONE 14
`define BIT_ADC_A_DONE 13
`define BIT_UART_A_TX 12
`define BIT_UART_A_RX 11
`define BIT_SPI_A_EVENT 10
`define BIT_SPI_A_FAULT 9
`define BIT_TIMER_C 8
`define BIT_TIMER_B 7
`define BIT_COMPARE_B 6
`define BIT_CAPTURE_B 5
`define BIT_DMA_CH0_DONE 4
`define BIT_TIMER_A 3
`define BIT_COMPARE_A 2
`define BIT_CAPTURE_A 1
`define BIT_EXT_IRQ_A 0

// ----------------------------------------------------------------
// Bit positions in the high flag register
// ----------------------------------------------------------------
`define BIT_UART_B_TX 15
`define BIT_UART_B_RX 14
`define BIT_EXT_IRQ_C 13
`define BIT_TIMER_E 12
`define BIT_TIMER_D 11
`define BIT_COMPARE_D 10
`define BIT_COMPARE_C 9
`define BIT_DMA_CH2_DONE 8
`define BIT_CAPTURE_H 7
`define BIT_CAPTURE_G 6
`define BIT_ADC_B_DONE 5
`define BIT_EXT_IRQ_B 4
`define BIT_PIN_CHANGE 3
`define BIT_HIGH_UNUSED 2
`define BIT_I2C_A_MASTER 1
`define BIT_I2C_A_SLAVE 0

`endif

/* File: design/irq_flags_pkg.sv */
// Types shared by the interrupt flag bank
package irq_flags_pkg;

  // ----------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------
  // One flag register word
  typedef logic [15:0] flag_word_t;

  // Register selected by an address
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_LOW = 2'b01,
    SEL_HIGH = 2'b10
  } reg_sel_t;

endpackage

/* File: design/interrupt_flag_status_bank.sv */
// Interrupt request flag bank: two sticky 16-bit flag registers
`include "irq_flags_map.svh"
`timescale 1ns/100ps
`default_nettype none

module interrupt_flag_status_bank
  import irq_flags_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request pulses from the sources, one bit per flag position
  input wire logic [15:0] req_low_i,
  input wire logic [15:0] req_high_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Pending flags toward the interrupt arbitration logic
  output logic [15:0] flags_low_o,
  output logic [15:0] flags_high_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Shared by the write path and the read path
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_W'(`ADDR_FLAGS_LOW)) begin
      sel = SEL_LOW;
    end else if (addr == ADDR_W'(`ADDR_FLAGS_HIGH)) begin
      sel = SEL_HIGH;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // Implemented positions
  // ----------------------------------------------------------------
  // Masks are built from the bit map and not typed in as a word, so a
  // source that moves cannot leave a stale bit behind in the mask.
  // Word with a single position set
  function automatic flag_word_t one_at(input int pos);
    flag_word_t w;
    w = `FLAGS_RST;
    w[pos] = 1'b1;
    return w;
  endfunction

  // Low word: the top position has no source and stays out
  localparam flag_word_t LOW_IMPL =
    one_at(`BIT_DMA_CH1_DONE) |
    one_at(`BIT_ADC_A_DONE) |
    one_at(`BIT_UART_A_TX) |
    one_at(`BIT_UART_A_RX) |
    one_at(`BIT_SPI_A_EVENT) |
    one_at(`BIT_SPI_A_FAULT) |
    one_at(`BIT_TIMER_C) |
    one_at(`BIT_TIMER_B) |
    one_at(`BIT_COMPARE_B) |
    one_at(`BIT_CAPTURE_B) |
    one_at(`BIT_DMA_CH0_DONE) |
    one_at(`BIT_TIMER_A) |
    one_at(`BIT_COMPARE_A) |
    one_at(`BIT_CAPTURE_A) |
    one_at(`BIT_EXT_IRQ_A);

  // High word: the unused middle position has no source and stays out
  localparam flag_word_t HIGH_IMPL =
    one_at(`BIT_UART_B_TX) |
    one_at(`BIT_UART_B_RX) |
    one_at(`BIT_EXT_IRQ_C) |
    one_at(`BIT_TIMER_E) |
    one_at(`BIT_TIMER_D) |
    one_at(`BIT_COMPARE_D) |
    one_at(`BIT_COMPARE_C) |
    one_at(`BIT_DMA_CH2_DONE) |
    one_at(`BIT_CAPTURE_H) |
    one_at(`BIT_CAPTURE_G) |
    one_at(`BIT_ADC_B_DONE) |
    one_at(`BIT_EXT_IRQ_B) |
    one_at(`BIT_PIN_CHANGE) |
    one_at(`BIT_I2C_A_MASTER) |
    one_at(`BIT_I2C_A_SLAVE);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  flag_word_t flags_low_r; // Low flag register
  flag_word_t flags_high_r; // High flag register
  flag_word_t flags_low_nxt; // Next value of the low register
  flag_word_t flags_high_nxt; // Next value of the high register
  flag_word_t rdata_r; // Read data, valid the cycle after a read
  logic wr_low; // Write strobe aimed at the low register
  logic wr_high; // Write strobe aimed at the high register

  assign wr_low = wr_i && (decode_addr(addr_i) == SEL_LOW);
  assign wr_high = wr_i && (decode_addr(addr_i) == SEL_HIGH);

  // ----------------------------------------------------------------
  // Per-bit next value
  // ----------------------------------------------------------------
  // A request in the same cycle as a clearing write wins, so no event
  // is lost; writing one forces a request for software test.
  // Unimplemented positions are held at zero by the mask.
  // Low word: bit gi follows source gi of the low request bus
  genvar gi;
  generate
    for (gi = 0; gi < $bits(flag_word_t); gi++) begin : g_low_bit
      assign flags_low_nxt[gi] = LOW_IMPL[gi] &
        (req_low_i[gi] | (wr_low ? wdata_i[gi] : flags_low_r[gi]));
    end
  endgenerate

  // High word: same rule, own loop so each word keeps its own mask
  genvar gj;
  generate
    for (gj = 0; gj < $bits(flag_word_t); gj++) begin : g_high_bit
      assign flags_high_nxt[gj] = HIGH_IMPL[gj] &
        (req_high_i[gj] | (wr_high ? wdata_i[gj] : flags_high_r[gj]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  // Low word clears on reset so nothing is pending at start-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_low_r <= `FLAGS_RST;
    end else begin
      flags_low_r <= flags_low_nxt;
    end
  end

  // High word, same treatment; kept apart so each word is one concern
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_high_r <= `FLAGS_RST;
    end else begin
      flags_high_r <= flags_high_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the strobe; otherwise zero.
  // Unmapped addresses read zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= `RDATA_IDLE;
    end else if (rd_i && decode_addr(addr_i) == SEL_LOW) begin
      rdata_r <= flags_low_r;
    end else if (rd_i && decode_addr(addr_i) == SEL_HIGH) begin
      rdata_r <= flags_high_r;
    end else begin
      rdata_r <= `RDATA_IDLE;
    end
  end

  assign rdata_o = rdata_r;
  assign flags_low_o = flags_low_r;
  assign flags_high_o = flags_high_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Every check below runs on the system clock; all but a_reset_clears rest during reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Helpers: which word a read was aimed at last cycle; the read data
  // checks look one cycle after the strobe
  logic rd_low_q; // A low read was issued last cycle
  logic rd_high_q; // A high read was issued last cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_low_q <= 1'b0;
      rd_high_q <= 1'b0;
    end else begin
      rd_low_q <= rd_i && decode_addr(addr_i) == SEL_LOW;
      rd_high_q <= rd_i && decode_addr(addr_i) == SEL_HIGH;
    end
  end

  a_req_sets_low: assert property (
    (req_low_i & `FLAGS_LOW_IMPL) != `FLAGS_RST |=>
      (flags_low_o & $past(req_low_i) & `FLAGS_LOW_IMPL) == ($past(req_low_i) & `FLAGS_LOW_IMPL))
    else $error("low flag missed its request");
  a_read_low_data: assert property (
    rd_low_q |-> rdata_o == $past(flags_low_o))
    else $error("low read data wrong");
  a_quiet_holds: assert property (
    !wr_i && req_low_i == `FLAGS_RST && req_high_i == `FLAGS_RST |=>
      $stable(flags_low_o) && $stable(flags_high_o))
    else $error("flags changed without cause");
  a_unused_zero: assert property (
    !flags_low_o[`BIT_LOW_UNUSED] && !flags_high_o[`BIT_HIGH_UNUSED])
    else $error("unimplemented flag set");
  // Low word: each source lands in its own position one cycle later
  a_dma_low_bits: assert property (
    req_low_i[`BIT_DMA_CH1_DONE] |=>
      flags_low_o[`BIT_DMA_CH1_DONE])
    else $error("dma 1 flag not set");
  a_dma_ch0_bit: assert property (
    req_low_i[`BIT_DMA_CH0_DONE] |=>
      flags_low_o[`BIT_DMA_CH0_DONE])
    else $error("dma 0 flag not set");
  a_adc_a_bit: assert property (
    req_low_i[`BIT_ADC_A_DONE] |=>
      flags_low_o[`BIT_ADC_A_DONE])
    else $error("adc flag not set");
  a_uart_a_bits: assert property (
    req_low_i[`BIT_UART_A_TX] |=>
      flags_low_o[`BIT_UART_A_TX])
    else $error("uart tx flag not set");
  a_uart_a_rx: assert property (
    req_low_i[`BIT_UART_A_RX] |=>
      flags_low_o[`BIT_UART_A_RX])
    else $error("uart rx flag not set");
  a_spi_a_bits: assert property (
    req_low_i[`BIT_SPI_A_FAULT] |=>
      flags_low_o[`BIT_SPI_A_FAULT])
    else $error("spi fault flag not set");
  a_spi_a_event: assert property (
    req_low_i[`BIT_SPI_A_EVENT] |=>
      flags_low_o[`BIT_SPI_A_EVENT])
    else $error("spi event flag not set");
  a_timer_low_bits: assert property (
    req_low_i[`BIT_TIMER_A] |=>
      flags_low_o[`BIT_TIMER_A])
    else $error("timer a flag not set");
  a_timer_b_bit: assert property (
    req_low_i[`BIT_TIMER_B] |=>
      flags_low_o[`BIT_TIMER_B])
    else $error("timer b flag not set");
  a_timer_c_bit: assert property (
    req_low_i[`BIT_TIMER_C] |=>
      flags_low_o[`BIT_TIMER_C])
    else $error("timer c flag not set");
  a_ch_b_bits: assert property (
    req_low_i[`BIT_COMPARE_B] |=>
      flags_low_o[`BIT_COMPARE_B])
    else $error("compare b flag not set");
  a_capture_b_bit: assert property (
    req_low_i[`BIT_CAPTURE_B] |=>
      flags_low_o[`BIT_CAPTURE_B])
    else $error("capture b flag not set");
  a_ch_a_bits: assert property (
    req_low_i[`BIT_COMPARE_A] |=>
      flags_low_o[`BIT_COMPARE_A])
    else $error("compare a flag not set");
  a_capture_a_bit: assert property (
    req_low_i[`BIT_CAPTURE_A] |=>
      flags_low_o[`BIT_CAPTURE_A])
    else $error("capture a flag not set");
  a_ext_a_bit: assert property (
    req_low_i[`BIT_EXT_IRQ_A] |=>
      flags_low_o[`BIT_EXT_IRQ_A])
    else $error("external flag not set");

  // High word: same one-cycle latching for every source
  a_uart_b_bits: assert property (
    req_high_i[`BIT_UART_B_TX] |=>
      flags_high_o[`BIT_UART_B_TX])
    else $error("uart b tx flag not set");
  a_uart_b_rx: assert property (
    req_high_i[`BIT_UART_B_RX] |=>
      flags_high_o[`BIT_UART_B_RX])
    else $error("uart b rx flag not set");
  a_ext_high_bits: assert property (
    req_high_i[`BIT_EXT_IRQ_C] |=>
      flags_high_o[`BIT_EXT_IRQ_C])
    else $error("external c flag not set");
  a_ext_b_bit: assert property (
    req_high_i[`BIT_EXT_IRQ_B] |=>
      flags_high_o[`BIT_EXT_IRQ_B])
    else $error("external b flag not set");
  a_timer_high_bits: assert property (
    req_high_i[`BIT_TIMER_E] |=>
      flags_high_o[`BIT_TIMER_E])
    else $error("timer e flag not set");
  a_timer_d_bit: assert property (
    req_high_i[`BIT_TIMER_D] |=>
      flags_high_o[`BIT_TIMER_D])
    else $error("timer d flag not set");
  a_compare_high: assert property (
    req_high_i[`BIT_COMPARE_D] |=>
      flags_high_o[`BIT_COMPARE_D])
    else $error("compare d flag not set");
  a_compare_c_bit: assert property (
    req_high_i[`BIT_COMPARE_C] |=>
      flags_high_o[`BIT_COMPARE_C])
    else $error("compare c flag not set");
  a_dma_high_bit: assert property (
    req_high_i[`BIT_DMA_CH2_DONE] |=>
      flags_high_o[`BIT_DMA_CH2_DONE])
    else $error("dma 2 flag not set");
  a_capture_high: assert property (
    req_high_i[`BIT_CAPTURE_H] |=>
      flags_high_o[`BIT_CAPTURE_H])
    else $error("capture h flag not set");
  a_capture_g_bit: assert property (
    req_high_i[`BIT_CAPTURE_G] |=>
      flags_high_o[`BIT_CAPTURE_G])
    else $error("capture g flag not set");
  a_adc_b_bit: assert property (
    req_high_i[`BIT_ADC_B_DONE] |=>
      flags_high_o[`BIT_ADC_B_DONE])
    else $error("adc b flag not set");
  a_pin_change_bit: assert property (
    req_high_i[`BIT_PIN_CHANGE] |=>
      flags_high_o[`BIT_PIN_CHANGE])
    else $error("pin change flag not set");
  a_i2c_a_bits: assert property (
    req_high_i[`BIT_I2C_A_MASTER] |=>
      flags_high_o[`BIT_I2C_A_MASTER])
    else $error("i2c master flag not set");
  a_i2c_slave_bit: assert property (
    req_high_i[`BIT_I2C_A_SLAVE] |=>
      flags_high_o[`BIT_I2C_A_SLAVE])
    else $error("i2c slave flag not set");
  a_reset_clears: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |-> flags_low_o == `FLAGS_RST && flags_high_o == `FLAGS_RST && rdata_o == `RDATA_IDLE)
    else $error("flags not clear in reset");
  a_write_clears: assert property (
    wr_low && req_low_i == `FLAGS_RST |=>
      flags_low_o == ($past(wdata_i) & `FLAGS_LOW_IMPL))
    else $error("low write not applied");
  // Read data follows the addressed word for exactly one cycle
  a_read_high_data: assert property (
    rd_high_q |-> rdata_o == $past(flags_high_o))
    else $error("high read data wrong");
  a_read_idle: assert property (
    !rd_low_q && !rd_high_q |-> rdata_o == `RDATA_IDLE)
    else $error("read data not idle");
  // Writes and requests are the only ways a flag may move
  a_write_high: assert property (
    wr_high && req_high_i == `FLAGS_RST |=>
      flags_high_o == ($past(wdata_i) & `FLAGS_HIGH_IMPL))
    else $error("high write not applied");
  a_low_no_spurious: assert property (
    !wr_low |=>
      (flags_low_o & ~$past(flags_low_o) & ~$past(req_low_i)) == `FLAGS_RST)
    else $error("low flag rose without request");
  a_high_no_spurious: assert property (
    !wr_high |=>
      (flags_high_o & ~$past(flags_high_o) & ~$past(req_high_i)) == `FLAGS_RST)
    else $error("high flag rose without request");
  a_low_sticky: assert property (
    !wr_low |=> ($past(flags_low_o) & ~flags_low_o) == `FLAGS_RST)
    else $error("low flag dropped without a write");
  a_high_sticky: assert property (
    !wr_high |=> ($past(flags_high_o) & ~flags_high_o) == `FLAGS_RST)
    else $error("high flag dropped without a write");

  // Main scenarios: set then read, clear, set against clear, force, stray read
  c_set_then_read: cover property (
    req_low_i[`BIT_TIMER_A] ##[1:4] (rd_i && decode_addr(addr_i) == SEL_LOW));
  c_clear_by_write: cover property (
    flags_high_o[`BIT_PIN_CHANGE] && wr_high && !wdata_i[`BIT_PIN_CHANGE]);
  c_set_beats_clear: cover property (
    wr_low && !wdata_i[`BIT_TIMER_A] && req_low_i[`BIT_TIMER_A]);
  c_forced_high: cover property (
    wr_high && (wdata_i & HIGH_IMPL) == HIGH_IMPL);
  c_unmapped_read: cover property (
    rd_i && decode_addr(addr_i) == SEL_NONE);

endmodule

`default_nettype wire

/* File: verif/req_source_model.sv */
// Model of the peripheral request sources feeding the flag bank
`timescale 1ns/100ps
`default_nettype none

module req_source_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command from the bench: which source fires
  input wire logic fire_i,
  input wire logic hi_i,
  input wire logic [3:0] bit_i,
  // Request lines toward the flag bank
  output logic [15:0] req_low_o,
  output logic [15:0] req_high_o
);
  // ----------------------------------------------------------------
  // Request pulses
  // ----------------------------------------------------------------
  // One-cycle pulse, then low again, so a flag that fails to hold shows up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_low_o <= 16'h0000;
      req_high_o <= 16'h0000;
    end else begin
      req_low_o <= (fire_i && !hi_i) ? (16'h0001 << bit_i) : 16'h0000;
      req_high_o <= (fire_i && hi_i) ? (16'h0001 << bit_i) : 16'h0000;
    end
  end
endmodule

`default_nettype wire

/* File: verif/tb_interrupt_flag_status_bank.sv */
// Self-checking testbench of the interrupt flag bank
`include "irq_flags_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_interrupt_flag_status_bank;
  import irq_flags_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic [3:0] addr = 4'h0;
  flag_word_t wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fire = 1'b0;
  logic fire_hi = 1'b0;
  logic [3:0] fire_bit = 4'h0;
  flag_word_t req_low, req_high, rdata, flags_low, flags_high;
  int fails = 0;
  int checked = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  interrupt_flag_status_bank #(.ADDR_W(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_low_i(req_low), .req_high_i(req_high),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .flags_low_o(flags_low), .flags_high_o(flags_high));

  req_source_model srcs (
    .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .hi_i(fire_hi), .bit_i(fire_bit),
    .req_low_o(req_low), .req_high_o(req_high));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input flag_word_t seen, input flag_word_t exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write; flags are settled just after the taking edge
  task automatic wr_reg(input logic [3:0] a, input flag_word_t d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd_chk(input logic [3:0] a, input flag_word_t exp);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Source pulses one cycle after the command; the flag lands one edge later
  task automatic fire_src(input logic h, input logic [3:0] b);
    @(posedge clk_i);
    fire <= 1'b1;
    fire_hi <= h;
    fire_bit <= b;
    @(posedge clk_i);
    fire <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the tests need well under 1000 cycles
  // ----------------------------------------------------------------
  initial begin
    #500000;
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int h;
    int b;
    flag_word_t exp;
    // Raise reset before the first edge so the clear is done when sampled
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(flags_low, 16'h0000);
    chk(flags_high, 16'h0000);
    rd_chk(`ADDR_FLAGS_LOW, 16'h0000);
    rd_chk(`ADDR_FLAGS_HIGH, 16'h0000);
    $display("test reset values done");
    // Every source in turn, unimplemented places included
    for (h = 0; h < 2; h++) begin
      for (b = 0; b < 16; b++) begin
        exp = (16'h0001 << b) & ((h != 0) ? `FLAGS_HIGH_IMPL : `FLAGS_LOW_IMPL);
        fire_src(h[0], b[3:0]);
        chk((h != 0) ? flags_high : flags_low, exp);
        chk((h != 0) ? flags_low : flags_high, 16'h0000);
        rd_chk((h != 0) ? `ADDR_FLAGS_HIGH : `ADDR_FLAGS_LOW, exp);
        wr_reg((h != 0) ? `ADDR_FLAGS_HIGH : `ADDR_FLAGS_LOW, 16'h0000);
        chk((h != 0) ? flags_high : flags_low, 16'h0000);
      end
    end
    $display("test source mapping done");
    // Software forcing all ones
    wr_reg(`ADDR_FLAGS_LOW, 16'hffff);
    wr_reg(`ADDR_FLAGS_HIGH, 16'hffff);
    rd_chk(`ADDR_FLAGS_LOW, `FLAGS_LOW_IMPL);
    rd_chk(`ADDR_FLAGS_HIGH, `FLAGS_HIGH_IMPL);
    @(posedge clk_i);
    #1;
    chk(rdata, 16'h0000);
    $display("test forced flags done");
    // A request in the same cycle as a clearing write must survive
    wr_reg(`ADDR_FLAGS_LOW, 16'h0000);
    wr_reg(`ADDR_FLAGS_HIGH, 16'h0000);
    @(posedge clk_i);
    fire <= 1'b1;
    fire_hi <= 1'b0;
    fire_bit <= 4'h3;
    @(posedge clk_i);
    fire <= 1'b0;
    addr <= `ADDR_FLAGS_LOW;
    wdata <= 16'h0000;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
    chk(flags_low, 16'h0008);
    $display("test set against clear done");
    // Unmapped address: write ignored, read gives zero
    wr_reg(4'h5, 16'hffff);
    rd_chk(4'h5, 16'h0000);
    chk(flags_low, 16'h0008);
    chk(flags_high, 16'h0000);
    $display("test unmapped address done");
    // Reset in mid-run drops every pending flag
    wr_reg(`ADDR_FLAGS_HIGH, 16'hffff);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(flags_low, 16'h0000);
    chk(flags_high, 16'h0000);
    rd_chk(`ADDR_FLAGS_HIGH, 16'h0000);
    $display("test mid-run reset done");
    results();
  end
endmodule

`default_nettype wire
